// ===== rtl/dpll_lock_and_phase_detect.sv
// Lock state control, bandwidth choice and phase detectors of the main loop.
// Assumes AXI4-Lite register access, a single clock, and reference and feedback
// levels already retimed to aclk by the surrounding logic.
`timescale 1ns/10ps
module dpll_lock_and_phase_detect
    import dpll_pkg::*;
#(
    parameter longint unsigned LOCK_CYC    = LOCK_QUAL_CYC,
    parameter longint unsigned TIMEOUT_CYC = PRELOCK_CYC
) (
    input  wire logic        aclk,          // system clock
    input  wire logic        aresetn,       // sync reset, active low
    input  wire logic        ce,            // clock enable, freezes state
    input  wire logic [7:0]  s_awaddr,      // write address
    input  wire logic        s_awvalid,     // write address valid
    output      logic        s_awready,     // write address ready
    input  wire logic [31:0] s_wdata,       // write data
    input  wire logic [3:0]  s_wstrb,       // write byte strobes
    input  wire logic        s_wvalid,      // write data valid
    output      logic        s_wready,      // write data ready
    output      logic [1:0]  s_bresp,       // write response
    output      logic        s_bvalid,      // write response valid
    input  wire logic        s_bready,      // write response ready
    input  wire logic [7:0]  s_araddr,      // read address
    input  wire logic        s_arvalid,     // read address valid
    output      logic        s_arready,     // read address ready
    output      logic [31:0] s_rdata,       // read data
    output      logic [1:0]  s_rresp,       // read response
    output      logic        s_rvalid,      // read data valid
    input  wire logic        s_rready,      // read data ready
    input  wire logic        ref_in,        // selected reference clock level
    input  wire logic        fb_in,         // feedback clock level
    input  wire logic        ref_applied,   // pulse: reference chosen and applied
    input  wire logic        prio_restored, // pulse: higher-priority ref back
    input  wire logic        phase_lock,    // level: detectors report lock
    output      lock_state_t state,         // lock state
    output      logic        reselect_req,  // pulse: choose another reference
    output      logic [3:0]  active_bw,     // bandwidth code in use
    output      logic        nearest_edge,  // nearest edge capture active
    output      phase_out_t  loop_phase     // phase word to loop filter
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] m);
        return (v > m) ? m : v;
    endfunction

    // Range n -> 2^(n+1)-1 UI, with n clamped to MC_CODE_MAX
    function automatic logic signed [14:0] mc_range(input logic [3:0] n);
        logic [3:0] c;
        c = clamp4(n, MC_CODE_MAX);
        return 15'((16'h0002 << c) - 16'h0001);
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] bw_q;
    logic [31:0] mcyc_q;
    logic [31:0] incfg_q;
    logic [31:0] ofs_q;
    logic [7:0]  awaddr_q;
    logic        aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_have_q;
    logic        do_write;
    loop_set_t   set;

    assign s_awready = ~aw_have_q & ~s_bvalid;
    assign s_wready  = ~w_have_q & ~s_bvalid;
    assign do_write  = ce & aw_have_q & w_have_q & ~s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (ce) begin
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= RST_CTRL;
            bw_q    <= RST_BW;
            mcyc_q  <= RST_MCYC;
            incfg_q <= RST_INCFG;
            ofs_q   <= 32'h0000_0000;
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp  <= RESP_OKAY;
                case (awaddr_q)
                    A_CTRL:  ctrl_q  <= merge(ctrl_q, wdata_q, wstrb_q);
                    A_BW:    bw_q    <= merge(bw_q, wdata_q, wstrb_q);
                    A_MCYC:  mcyc_q  <= merge(mcyc_q, wdata_q, wstrb_q);
                    A_INCFG: incfg_q <= merge(incfg_q, wdata_q, wstrb_q);
                    A_OFS:   ofs_q   <= merge(ofs_q, wdata_q, wstrb_q);
                    default: s_bresp <= RESP_SLVERR;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Out-of-range codes saturate rather than wrap to a narrow loop
    always_comb begin
        set.acq_bw    = clamp4(bw_q[3:0], BW_CODE_MAX);
        set.lock_bw   = clamp4(bw_q[7:4], BW_CODE_MAX);
        set.main_damp = 3'(clamp4({1'b0, bw_q[10:8]}, {1'b0, DAMP_MAX}));
        set.sec_bw    = 2'(clamp4({2'b00, bw_q[13:12]}, {2'b00, SEC_BW_MAX}));
        set.sec_damp  = 3'(clamp4({1'b0, bw_q[18:16]}, {1'b0, DAMP_MAX}));
    end

    // ------------------------------------------------------------
    // Lock state machine
    // ------------------------------------------------------------
    logic [TMR_W-1:0] qual_q;
    logic [TMR_W-1:0] tmo_q;
    logic             qualified;
    logic             timed_out;
    logic             revert_ev;

    assign qualified = (qual_q >= TMR_W'(LOCK_CYC - 64'd1)) & phase_lock;
    assign timed_out = tmo_q >= TMR_W'(TIMEOUT_CYC - 64'd1);
    assign revert_ev = ctrl_q[F_REVERT] & prio_restored;

    // Continuous lock time; any drop restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qual_q <= '0;
        end else if (ce) begin
            if (!phase_lock || state != ST_PRELOCK2) begin
                qual_q <= '0;
            end else if (!qualified) begin
                qual_q <= qual_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_q <= '0;
        end else if (ce) begin
            if (state != ST_PRELOCK2) begin
                tmo_q <= '0;
            end else begin
                tmo_q <= tmo_q + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_HOLDOVER;
            reselect_req <= 1'b0;
        end else if (ce) begin
            reselect_req <= 1'b0;
            case (state)
                ST_HOLDOVER: begin
                    if (ref_applied || revert_ev) begin
                        state <= ST_PRELOCK2;
                    end
                end
                ST_PRELOCK2: begin
                    if (qualified) begin
                        state <= ST_LOCKED;
                    end else if (timed_out) begin
                        state        <= ST_HOLDOVER;
                        reselect_req <= 1'b1;
                    end
                end
                ST_LOCKED: begin
                    if (revert_ev || !phase_lock) begin
                        state <= ST_PRELOCK2;
                    end
                end
                default: state <= ST_HOLDOVER;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bandwidth and capture mode
    // ------------------------------------------------------------
    logic mc_en;
    logic mc_use;

    assign mc_en  = mcyc_q[F_MC_EN];
    assign mc_use = mcyc_q[F_MC_USE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_bw <= 4'h0;
        end else if (ce) begin
            if (ctrl_q[F_AUTO_BW] && state != ST_LOCKED) begin
                active_bw <= set.acq_bw;
            end else begin
                active_bw <= set.lock_bw;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nearest_edge <= 1'b0;
        end else if (ce) begin
            // Inhibit wins so frequency locking is never given up
            nearest_edge <= ~ctrl_q[F_NE_INH] & ~mc_en & phase_lock;
        end
    end

    // ------------------------------------------------------------
    // Reference conditioning
    // ------------------------------------------------------------
    logic        ref_q;
    logic        fb_q;
    logic        half_q;
    logic [15:0] div8k_q;
    logic        ref_edge;
    logic        fb_edge;
    logic        pre_tick;
    logic        ref_tick;

    assign ref_edge = ref_in & ~ref_q;
    assign fb_edge  = fb_in & ~fb_q;
    // Fast input halved so the detector never sees above 77.76 MHz
    assign pre_tick = ref_edge & (~incfg_q[F_HS_IN] | half_q);
    assign ref_tick = pre_tick & (~incfg_q[F_DIVIDE_TO_8KHZ_LOCK] | div8k_q == 16'h0000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q   <= 1'b0;
            fb_q    <= 1'b0;
            half_q  <= 1'b0;
            div8k_q <= 16'h0000;
        end else if (ce) begin
            ref_q <= ref_in;
            fb_q  <= fb_in;
            if (ref_edge) begin
                half_q <= ~half_q;
            end
            if (pre_tick) begin
                // Ratio to 8 kHz held in the upper half of the input register
                div8k_q <= (div8k_q == 16'h0000) ? incfg_q[31:16] : div8k_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase detectors
    // ------------------------------------------------------------
    logic        [PER_W-1:0] cnt_q;
    logic        [PER_W-1:0] per_q;
    logic signed [14:0]      ui_q;
    logic signed [PER_W:0]   fine;
    logic signed [31:0]      full;
    logic signed [14:0]      rng;
    logic signed [15:0]      ui_next;

    assign rng = mc_range(mcyc_q[3:0]);

    // Cycle count since last reference tick, one aclk cycle per step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            per_q <= '0;
        end else if (ce) begin
            if (ref_tick) begin
                per_q <= cnt_q;
                cnt_q <= '0;
            end else if (~&cnt_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_comb begin
        fine = $signed({1'b0, cnt_q});
        if (nearest_edge && cnt_q > (per_q >> 1)) begin
            fine = $signed({1'b0, cnt_q}) - $signed({1'b0, per_q});
        end
    end

    always_comb begin
        ui_next = 16'(ui_q);
        if (ref_tick && !fb_edge) begin
            ui_next = 16'(ui_q) + 16'sh0001;
        end else if (fb_edge && !ref_tick) begin
            ui_next = 16'(ui_q) - 16'sh0001;
        end
    end

    // Slip count stays live regardless of the loop-use bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ui_q <= '0;
        end else if (ce) begin
            if (!mc_en) begin
                ui_q <= '0;
            end else if (ui_next > 16'(rng)) begin
                ui_q <= rng;
            end else if (ui_next < -16'(rng)) begin
                ui_q <= -rng;
            end else begin
                ui_q <= 15'(ui_next);
            end
        end
    end

    assign full = 32'(fine) + 32'(ui_q) * 32'($signed({1'b0, per_q}));

    // Offset in 6 ps steps, saturated at the 200 ns limit
    logic signed [16:0] ofs_sat;
    always_comb begin
        ofs_sat = $signed(ofs_q[16:0]);
        if (ofs_sat > $signed({1'b0, OFS_LIMIT})) begin
            ofs_sat = $signed({1'b0, OFS_LIMIT});
        end else if (ofs_sat < -$signed({1'b0, OFS_LIMIT})) begin
            ofs_sat = -$signed({1'b0, OFS_LIMIT});
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_phase <= '0;
        end else if (ce) begin
            loop_phase.valid <= fb_edge;
            if (fb_edge) begin
                if (mc_en && mc_use) begin
                    loop_phase.phase <= full;
                end else begin
                    loop_phase.phase <= 32'(fine);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [31:0] rd;
    logic        rd_ok;

    assign s_arready = ~s_rvalid;

    always_comb begin
        rd_ok = 1'b1;
        case (s_araddr)
            A_CTRL:   rd = ctrl_q;
            A_BW:     rd = {13'h0000, set.sec_damp, 2'b00, set.sec_bw, 1'b0,
                            set.main_damp, set.lock_bw, set.acq_bw};
            A_MCYC:   rd = mcyc_q;
            A_INCFG:  rd = incfg_q;
            A_OFS:    rd = 32'(ofs_sat);
            A_STATUS: rd = {8'h00, 5'(LOGIC_MULT), 3'b000, BW_STEPS[3:0], active_bw,
                            3'b000, nearest_edge, phase_lock, state};
            A_PHASE:  rd = {{17{ui_q[14]}}, ui_q};
            default: begin
                rd    = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd;
                s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ===== rtl/dpll_pkg.sv
// Constants, register map and carrier types of the DPLL lock and phase detect core.
// Assumes one 125 MHz clock; reference and feedback levels come in synchronous to it.
package dpll_pkg;

    localparam longint unsigned CLK_HZ        = 64'd125_000_000;
    localparam longint unsigned LOCK_QUAL_S   = 64'd1;
    localparam longint unsigned PRELOCK_MAX_S = 64'd100;
    localparam longint unsigned LOCK_QUAL_CYC = CLK_HZ * LOCK_QUAL_S;
    localparam longint unsigned PRELOCK_CYC   = CLK_HZ * PRELOCK_MAX_S;
    localparam int              TMR_W         = 36;

    localparam int LOGIC_CLK_KHZ = 204800;
    localparam int OSC_KHZ       = 12800;
    localparam int LOGIC_MULT    = LOGIC_CLK_KHZ / OSC_KHZ;

    localparam int              MIN_REF_HZ = 2000;
    localparam int              PER_W      = $clog2(int'(CLK_HZ) / MIN_REF_HZ) + 2;

    localparam logic [4:0]  BW_STEPS     = 5'h0A;
    localparam logic [3:0]  BW_CODE_MAX  = 4'h9;
    localparam logic [2:0]  DAMP_MAX     = 3'h4;
    localparam logic [1:0]  SEC_BW_MAX   = 2'h2;
    localparam logic [3:0]  MC_CODE_MAX  = 4'hC;
    localparam logic [15:0] OFS_LIMIT    = 16'h8235;        // 200 ns / 6 ps

    // Register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_BW     = 8'h04;
    localparam logic [7:0] A_MCYC   = 8'h08;
    localparam logic [7:0] A_INCFG  = 8'h0C;
    localparam logic [7:0] A_OFS    = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_PHASE  = 8'h18;

    // Field positions
    localparam int F_REVERT  = 0;
    localparam int F_NE_INH  = 6;
    localparam int F_AUTO_BW = 7;
    localparam int F_MC_EN   = 6;
    localparam int F_MC_USE  = 5;
    localparam int F_HS_IN   = 0;
    localparam int F_DIVIDE_TO_8KHZ_LOCK  = 6;

    localparam logic [31:0] RST_CTRL  = 32'h0000_0080;
    localparam logic [31:0] RST_BW    = 32'h0002_2259;
    localparam logic [31:0] RST_MCYC  = 32'h0000_0000;
    localparam logic [31:0] RST_INCFG = 32'h3CAF_0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_HOLDOVER = 3'b001,
        ST_PRELOCK2 = 3'b010,
        ST_LOCKED   = 3'b100
    } lock_state_t;

    typedef struct packed {
        logic [3:0] acq_bw;
        logic [3:0] lock_bw;
        logic [2:0] main_damp;
        logic [1:0] sec_bw;
        logic [2:0] sec_damp;
    } loop_set_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] phase;
    } phase_out_t;

endpackage

// ===== test/dpll_lock_and_phase_detect_sva.sv
// Checker for the lock controller and phase detector ports.
// Assumes it is bound to the core; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module dpll_lock_and_phase_detect_sva
    import dpll_pkg::*;
#(
    parameter longint unsigned LOCK_CYC    = LOCK_QUAL_CYC,
    parameter longint unsigned TIMEOUT_CYC = PRELOCK_CYC
) (
    input wire logic        aclk,          // clock
    input wire logic        aresetn,       // reset, active low
    input wire logic        ce,            // clock enable
    input wire logic        s_arready,     // read address ready
    input wire logic        s_rvalid,      // read data valid
    input wire logic        s_rready,      // read data ready
    input wire logic        fb_in,         // feedback level
    input wire logic        ref_applied,   // reference applied
    input wire logic        prio_restored, // priority reference back
    input wire logic        phase_lock,    // lock indication
    input lock_state_t      state,         // lock state
    input wire logic        reselect_req,  // reselect pulse
    input wire logic        nearest_edge,  // nearest edge active
    input phase_out_t       loop_phase     // phase word
);
    longint unsigned pre_q;
    longint unsigned lk_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles in prelock, and run of lock indication within it
    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_PRELOCK2) pre_q <= 0;
        else if (ce) pre_q <= pre_q + 1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_PRELOCK2 || !phase_lock) lk_q <= 0;
        else if (ce) lk_q <= lk_q + 1;
    end
    hold_to_pre_a: assert property (state == ST_HOLDOVER && ref_applied && ce
        |=> state == ST_PRELOCK2) else $error("no prelock after reference applied");
    hold_stay_a: assert property (state == ST_HOLDOVER && !ref_applied && !prio_restored
        |=> state == ST_HOLDOVER) else $error("holdover left without cause");
    lock_qual_a: assert property ($rose(state == ST_LOCKED) |-> $past(lk_q) + 2 >= LOCK_CYC)
        else $error("locked before qualification time");
    lock_bound_a: assert property (lk_q <= LOCK_CYC + 2)
        else $error("lock not reached in time");
    prelock_tmo_a: assert property (pre_q <= TIMEOUT_CYC + 2)
        else $error("prelock overstayed its limit");
    reselect_hold_a: assert property (reselect_req |-> state == ST_HOLDOVER ##1 !reselect_req)
        else $error("reselect not a single pulse in holdover");
    near_lock_a: assert property (nearest_edge |-> $past(phase_lock))
        else $error("nearest edge without phase lock");
    fb_phase_a: assert property ($rose(fb_in) |-> ##[1:3] loop_phase.valid)
        else $error("no phase word after feedback edge");
    rvalid_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid)
        else $error("read data dropped before it was taken");
    cover property ($rose(state == ST_LOCKED));
    cover property (reselect_req);
    cover property ($rose(nearest_edge));
endmodule

bind dpll_lock_and_phase_detect dpll_lock_and_phase_detect_sva #(
    .LOCK_CYC(LOCK_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) dpll_lock_and_phase_detect_sva_inst (
    .aclk, .aresetn, .ce, .s_arready, .s_rvalid, .s_rready, .fb_in, .ref_applied, .prio_restored,
    .phase_lock, .state, .reselect_req, .nearest_edge, .loop_phase);

// ===== test/dpll_lock_and_phase_detect_tb.sv
// Self-checking bench for the lock controller, bandwidth choice and phase detector.
// Assumes short lock and timeout counts so the run stays brief.
`timescale 1ns/10ps
module dpll_lock_and_phase_detect_tb import dpll_pkg::*;;
    localparam longint unsigned LCK = 64'd20;
    localparam longint unsigned TMO = 64'd200;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, s_awvalid = 1'b0, s_wvalid = 1'b0;
    logic s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0, ref_applied = 1'b0;
    logic prio_restored = 1'b0, phase_lock = 1'b0, run_ref = 1'b0, run_fb = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rd;
    logic [3:0] s_wstrb = 4'hF, active_bw;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ref_in, fb_in;
    logic reselect_req, nearest_edge;
    logic [1:0] s_bresp, s_rresp, rsp;
    lock_state_t state;
    phase_out_t loop_phase;
    int failures = 0, comparisons = 0, cyc = 0, n;
    always #4 aclk = ~aclk;
    dpll_lock_and_phase_detect #(.LOCK_CYC(LCK), .TIMEOUT_CYC(TMO)) dpll_lock_and_phase_detect_inst (
        .aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .ref_in, .fb_in, .ref_applied,
        .prio_restored, .phase_lock, .state, .reselect_req, .active_bw, .nearest_edge,
        .loop_phase);
    ref_clock_source ref_clock_source_inst (.aclk, .run_ref, .run_fb, .ref_in, .fb_in);
    // --------------------------------------------------------------------
    // Bus and compare helpers
    // --------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Trailing idle edge keeps two calls from driving one signal in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rsp = s_bresp;
        s_bready <= 1'b0;
        tick(1);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        chk(nm, 32'(s_rresp), 32'(er));
        s_rready <= 1'b0;
        tick(1);
        if (e !== 32'hFFFF_FFFF) chk(nm, rd, e);
    endtask
    task automatic pulse_prio;
        prio_restored <= 1'b1;
        @(posedge aclk);
        prio_restored <= 1'b0;
        tick(2);
    endtask
    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    task automatic t_regs;
        rchk("ctrl", A_CTRL, RST_CTRL, RESP_OKAY);
        rchk("bw", A_BW, RST_BW, RESP_OKAY);
        rchk("mcyc", A_MCYC, RST_MCYC, RESP_OKAY);
        rchk("incfg", A_INCFG, RST_INCFG, RESP_OKAY);
        rchk("unmapped", 8'h1C, 32'h0000_0000, RESP_SLVERR);
        wr(A_STATUS, 32'hFFFF_FFFF);
        chk("ro_write", 32'(rsp), 32'(RESP_SLVERR));
        wr(A_BW, 32'h0007_34FF);
        rchk("bw_clamp", A_BW, 32'h0004_2499, RESP_OKAY);
        wr(A_OFS, 32'h0000_FFFF);
        rchk("ofs_sat", A_OFS, 32'(OFS_LIMIT), RESP_OKAY);
        wr(A_BW, RST_BW);
        rchk("status", A_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        chk("steps", 32'(rd[15:12]), 32'h0000_000A);
        chk("mult", 32'(rd[23:19]), 32'h0000_0010);
    endtask
    task automatic t_lock;
        chk("acq_bw", 32'(active_bw), 32'(RST_BW[3:0]));
        ref_applied <= 1'b1;
        phase_lock <= 1'b1;
        @(posedge aclk);
        ref_applied <= 1'b0;
        n = 0;
        while (state !== ST_LOCKED) begin
            @(posedge aclk);
            n++;
        end
        chk("lock_time", 32'(n >= LCK && n <= LCK + 3), 32'h1);
        tick(2);
        chk("lock_bw", 32'(active_bw), 32'(RST_BW[7:4]));
        chk("near_edge", 32'(nearest_edge), 32'h1);
        wr(A_CTRL, 32'h0000_00C0);
        tick(2);
        chk("ne_inhibit", 32'(nearest_edge), 32'h0);
        phase_lock <= 1'b0;
        while (state !== ST_PRELOCK2) @(posedge aclk);
        n = 0;
        while (!reselect_req) begin
            @(posedge aclk);
            n++;
        end
        chk("timeout", 32'(n + 3 >= TMO && n <= TMO + 3), 32'h1);
        chk("reselect", 32'(state), 32'(ST_HOLDOVER));
    endtask
    task automatic t_revert;
        wr(A_CTRL, 32'h0000_0000);
        tick(2);
        chk("fixed_bw", 32'(active_bw), 32'(RST_BW[7:4]));
        pulse_prio;
        chk("no_revert", 32'(state), 32'(ST_HOLDOVER));
        wr(A_CTRL, 32'h0000_0001);
        ce <= 1'b0;
        pulse_prio;
        chk("ce_freeze", 32'(state), 32'(ST_HOLDOVER));
        ce <= 1'b1;
        pulse_prio;
        chk("revert", 32'(state), 32'(ST_PRELOCK2));
    endtask
    // Feedback held still, so the slip count climbs to its clamp
    task automatic t_phase;
        run_ref <= 1'b1;
        wr(A_MCYC, 32'h0000_0062);
        tick(200);
        rchk("ui_small", A_PHASE, 32'h0000_0007, RESP_OKAY);
        wr(A_MCYC, 32'h0000_004F);
        tick(33000);
        rchk("ui_max", A_PHASE, 32'h0000_1FFF, RESP_OKAY);
        wr(A_MCYC, 32'h0000_000F);
        rchk("ui_off", A_PHASE, 32'h0000_0000, RESP_OKAY);
        run_fb <= 1'b1;
        tick(40);
        chk("phase_limit", 32'(loop_phase.phase < 32'd4), 32'h1);
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            final_report;
        end
    end
    initial begin
        tick(20);
        aresetn <= 1'b1;
        tick(1);
        t_regs;
        t_lock;
        t_revert;
        t_phase;
        final_report;
    end
endmodule

// ===== test/ref_clock_source.sv
// Behavioural source of the selected reference and of the feedback clock.
// Assumes the bench clock; each clock stands low while it is not enabled.
`timescale 1ns/10ps
module ref_clock_source #(
    parameter int HALF = 2
) (
    input  wire logic aclk,    // bench clock
    input  wire logic run_ref, // reference running
    input  wire logic run_fb,  // feedback running
    output      logic ref_in,  // reference level
    output      logic fb_in    // feedback level
);
    int cnt_q = 0;
    initial begin
        ref_in = 1'b0;
        fb_in  = 1'b0;
    end
    // Spot rate aclk/(2*HALF), well inside the accepted input range
    always @(posedge aclk) begin
        cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
        if (cnt_q == HALF - 1) begin
            ref_in <= run_ref ? ~ref_in : 1'b0;
            fb_in  <= run_fb ? ~fb_in : 1'b0;
        end
    end
endmodule
